// >>> hdl/lnbc_pkg.sv
/*
   lnbc_pkg: selector codes, field positions, masks, reset values and the
   nominal output-level table of the dual coax supply control bank.
   Assumes every user writes names as lnbc_pkg::name; nothing is imported.
*/
package lnbc_pkg;

   // register selector, bits 7:6 of every written byte
   localparam int SEL_HI = 7;
   localparam int SEL_LO = 6;
   localparam logic [1:0] SEL_CH1_VOLT = 2'h0;
   localparam logic [1:0] SEL_CH2_VOLT = 2'h1;
   localparam logic [1:0] SEL_CH1_TONE = 2'h2;
   localparam logic [1:0] SEL_CH2_TONE = 2'h3;
   localparam int NUM_REGS = 4;
   localparam int NUM_CH = 2;

   // data field of each register
   localparam int FIELD_W = 6;
   localparam logic [5:0] FIELD_RESET = 6'h00;
   localparam logic [5:0] VOLT_MASK = 6'h3f;
   localparam logic [5:0] TONE_MASK = 6'h07;

   // voltage-and-enable register fields
   localparam int VOLT_STEP_LO = 0;
   localparam int VOLT_RANGE_BIT = 3;
   localparam int TIMER_EN_BIT = 4;
   localparam int OUT_EN_BIT = 5;
   localparam int VCODE_W = 4;

   // tone-and-cable-test register fields
   localparam int TONE_SRC_BIT = 0;
   localparam int TONE_GATE_BIT = 1;
   localparam int CABLE_TEST_BIT = 2;

   // overcurrent timers are always running
   localparam logic TIMER_ALWAYS_ON = 1'h1;

   // nominal output level per voltage code, millivolts
   localparam int LEVEL_W = 16;
   typedef logic [LEVEL_W-1:0] lnbc_level_t;
   localparam lnbc_level_t LEVEL_MV [16] = '{
      16'h31a5, 16'h32f2, 16'h343f, 16'h358d,
      16'h36da, 16'h3827, 16'h3975, 16'h3ac2,
      16'h467a, 16'h47c7, 16'h4915, 16'h4a62,
      16'h4baf, 16'h4cfd, 16'h4e4a, 16'h4f97
   };

endpackage : lnbc_pkg

// >>> hdl/lnbc_chan_if.sv
/*
   lnbc_chan_if: carrier between the control bank and one channel engine.
   Assumes all inputs toward the engine are already in the clk domain.
*/
`timescale 1ns/1ps
interface lnbc_chan_if;
   logic [3:0] volt_code;
   logic tone_source_select;
   logic tone_gate_field;
   logic cable_test_field;
   logic external_modulation_gating;
   logic int_tone;
   logic ext_tone;
   logic cmp_above;
   logic cmp_below;
   logic tone_out;
   logic cable_disconnected_flag;
   logic regulator_disable;
   logic current_source_enable;
   logic boost_raise;
   lnbc_pkg::lnbc_level_t level_mv;

   modport bank (
      output volt_code, tone_source_select, tone_gate_field, cable_test_field,
      output external_modulation_gating, int_tone, ext_tone, cmp_above, cmp_below,
      input tone_out, cable_disconnected_flag, regulator_disable,
      input current_source_enable, boost_raise, level_mv
   );
   modport chan (
      input volt_code, tone_source_select, tone_gate_field, cable_test_field,
      input external_modulation_gating, int_tone, ext_tone, cmp_above, cmp_below,
      output tone_out, cable_disconnected_flag, regulator_disable,
      output current_source_enable, boost_raise, level_mv
   );
endinterface : lnbc_chan_if

// >>> hdl/lnbc_chan.sv
/*
   lnbc_chan: one channel engine; tone selection and gating, cable test
   drive, disconnect flag and nominal level decode, all outputs registered.
   Assumes synchronised inputs through the interface and one clock.
*/
`timescale 1ns/1ps
module lnbc_chan (
   input wire logic clk,
   input wire logic arst_n,
   lnbc_chan_if.chan cif
);

   logic sel_tone;
   logic gate_on;
   logic tone_d;
   logic tone_q;
   logic flag_d;
   logic flag_q;
   logic test_q;
   lnbc_pkg::lnbc_level_t level_q;

   // source pick then gate; external gating overrides the gate field
   assign sel_tone = cif.tone_source_select ? cif.int_tone : cif.ext_tone;
   assign gate_on = cif.external_modulation_gating ? cif.ext_tone : cif.tone_gate_field;
   assign tone_d = sel_tone & gate_on;

   // disconnect flag: set above 21 V, cleared below 19.95 V, held between
   assign flag_d = !cif.cable_test_field ? 1'b0 :
                   cif.cmp_above ? 1'b1 :
                   cif.cmp_below ? 1'b0 :
                   flag_q;

   // output flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tone_q <= 1'b0;
         flag_q <= 1'b0;
         test_q <= 1'b0;
         level_q <= lnbc_pkg::LEVEL_MV[0];
      end else begin
         tone_q <= tone_d;
         flag_q <= flag_d;
         test_q <= cif.cable_test_field;
         level_q <= lnbc_pkg::LEVEL_MV[cif.volt_code];
      end
   end

   assign cif.tone_out = tone_q;
   assign cif.cable_disconnected_flag = flag_q;
   assign cif.regulator_disable = test_q;
   assign cif.current_source_enable = test_q;
   assign cif.boost_raise = test_q;
   assign cif.level_mv = level_q;

endmodule : lnbc_chan

// >>> hdl/lnbc_bank.sv
/*
   lnbc_bank: write-only control bank of a dual coax supply regulator.
   Four six-bit registers are picked by the top two bits of each byte that
   the serial front end hands over, and drive two channel engines.
   Assumes the front end raises wr_strobe for one clk cycle once a data byte
   is fully received and acknowledged; the analog pins are asynchronous.
*/
//
// Behaviour
// - selector 10 picks channel 1 tone register, 11 channel 2 tone register
// - selector 00 picks channel 1 voltage register, 01 channel 2 voltage register
// - every control field resets to zero at power-up
// - range bit chooses low level 12.709 V or high level 18.042 V
// - three step bits add 333 mV each on top of the base level
// - four-bit code decodes to sixteen nominal levels, 12.709 V to 20.375 V
// - overcurrent timers stay active whatever bit 4 holds
// - output enable bit switches the channel supply on or off
// - tone source bit picks external input or internal oscillator
// - tone gate bit turns the selected tone off or on
// - with external modulation gating the external input governs the tone
// - cable test disables regulator, enables current source, raises boost
// - during test, comparator above 21 V sets the disconnected flag
// - during test, comparator below 19.95 V clears the disconnected flag
`timescale 1ns/1ps
module lnbc_bank (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic int_tone_in,
   input wire logic [1:0] ext_tone_in,
   input wire logic [1:0] ext_mod_gating_in,
   input wire logic [1:0] cmp_above_21v,
   input wire logic [1:0] cmp_below_19v95,
   output logic [1:0][3:0] volt_code,
   output logic [1:0] supply_enable,
   output logic [1:0] overcurrent_timer_active,
   output logic [1:0] tone_source,
   output logic [1:0] tone_out,
   output logic [1:0] regulator_disable,
   output logic [1:0] current_source_enable,
   output logic [1:0] boost_raise,
   output logic [1:0] cable_disconnected_flag,
   output logic [1:0][15:0] level_mv
);

   localparam int SYNC_W = 9;

   logic [1:0] sel;
   logic [lnbc_pkg::NUM_REGS-1:0] hit;
   // unpacked so that each register flop group has its own process
   logic [lnbc_pkg::FIELD_W-1:0] field_q [lnbc_pkg::NUM_REGS];
   logic [SYNC_W-1:0] pins;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic int_tone_s;
   logic [1:0] ext_tone_s;
   logic [1:0] ext_gate_s;
   logic [1:0] above_s;
   logic [1:0] below_s;
   logic [1:0] timer_q;

   // selector taken from the top two bits of the byte
   assign sel = wr_data[lnbc_pkg::SEL_HI:lnbc_pkg::SEL_LO];
   assign hit[0] = wr_strobe && (sel == lnbc_pkg::SEL_CH1_VOLT);
   assign hit[1] = wr_strobe && (sel == lnbc_pkg::SEL_CH2_VOLT);
   assign hit[2] = wr_strobe && (sel == lnbc_pkg::SEL_CH1_TONE);
   assign hit[3] = wr_strobe && (sel == lnbc_pkg::SEL_CH2_TONE);

   // one write per strobe is all the host ever sends
   genvar r;
   for (r = 0; r < lnbc_pkg::NUM_REGS; r++) begin : g_reg
      localparam logic [5:0] MASK = (r < lnbc_pkg::NUM_CH) ? lnbc_pkg::VOLT_MASK
                                                        : lnbc_pkg::TONE_MASK;
      // register store; unused tone bits never captured
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            field_q[r] <= lnbc_pkg::FIELD_RESET;
         end else if (hit[r]) begin
            field_q[r] <= wr_data[lnbc_pkg::FIELD_W-1:0] & MASK;
         end
      end
   end

   // asynchronous pins gathered for the two-stage synchroniser
   assign pins = {int_tone_in, ext_tone_in, ext_mod_gating_in, cmp_above_21v, cmp_below_19v95};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
      end
   end

   // synchronised pin fields
   assign int_tone_s = sync2_q[8];
   assign ext_tone_s = sync2_q[7:6];
   assign ext_gate_s = sync2_q[5:4];
   assign above_s = sync2_q[3:2];
   assign below_s = sync2_q[1:0];

   // timers run regardless of the stored bit
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_q <= {lnbc_pkg::NUM_CH{lnbc_pkg::TIMER_ALWAYS_ON}};
      end else begin
         timer_q <= {lnbc_pkg::NUM_CH{lnbc_pkg::TIMER_ALWAYS_ON}};
      end
   end
   assign overcurrent_timer_active = timer_q;

   // per-channel wiring to the engines
   genvar c;
   for (c = 0; c < lnbc_pkg::NUM_CH; c++) begin : g_ch
      lnbc_chan_if cif ();
      // voltage register of channel c sits at index c, tone register at c+2
      assign cif.volt_code = field_q[c][lnbc_pkg::VOLT_RANGE_BIT:lnbc_pkg::VOLT_STEP_LO];
      assign cif.tone_source_select = field_q[c+lnbc_pkg::NUM_CH][lnbc_pkg::TONE_SRC_BIT];
      assign cif.tone_gate_field = field_q[c+lnbc_pkg::NUM_CH][lnbc_pkg::TONE_GATE_BIT];
      assign cif.cable_test_field = field_q[c+lnbc_pkg::NUM_CH][lnbc_pkg::CABLE_TEST_BIT];
      assign cif.external_modulation_gating = ext_gate_s[c];
      assign cif.int_tone = int_tone_s;
      assign cif.ext_tone = ext_tone_s[c];
      assign cif.cmp_above = above_s[c];
      assign cif.cmp_below = below_s[c];

      lnbc_chan u_chan (
         .clk (clk),
         .arst_n (arst_n),
         .cif (cif)
      );

      // outputs straight from register or engine flops
      assign volt_code[c] = field_q[c][lnbc_pkg::VOLT_RANGE_BIT:lnbc_pkg::VOLT_STEP_LO];
      assign supply_enable[c] = field_q[c][lnbc_pkg::OUT_EN_BIT];
      assign tone_source[c] = field_q[c+lnbc_pkg::NUM_CH][lnbc_pkg::TONE_SRC_BIT];
      assign tone_out[c] = cif.tone_out;
      assign regulator_disable[c] = cif.regulator_disable;
      assign current_source_enable[c] = cif.current_source_enable;
      assign boost_raise[c] = cif.boost_raise;
      assign cable_disconnected_flag[c] = cif.cable_disconnected_flag;
      assign level_mv[c] = cif.level_mv;
   end

endmodule : lnbc_bank

// >>> testbench/lnbc_host_model.sv
/* lnbc_host_model: host that hands over one acknowledged byte per transfer.
   assumes the bank samples wr_strobe on the rising clk edge */
`timescale 1ns/1ps
module lnbc_host_model (
   input wire logic clk,
   output logic [7:0] wr_data = 8'h00,
   output logic wr_strobe = 1'b0
);
   // one byte per addressed transfer; a released bus shows the inverse
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      wr_data <= b;
      wr_strobe <= 1'b1;
      @(posedge clk);
      wr_strobe <= 1'b0;
      wr_data <= ~b;
   endtask : send
endmodule : lnbc_host_model

// >>> testbench/lnbc_bank_checker.sv
/* lnbc_bank_checker: port properties of the control bank.
   assumes a bind onto lnbc_bank, one clock, async active-low reset */
`timescale 1ns/1ps
module lnbc_bank_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic [1:0] cmp_above_21v,
   input wire logic [1:0] cmp_below_19v95,
   input wire logic [1:0][3:0] volt_code,
   input wire logic [1:0] supply_enable,
   input wire logic [1:0] overcurrent_timer_active,
   input wire logic [1:0] tone_source,
   input wire logic [1:0] regulator_disable,
   input wire logic [1:0] cable_disconnected_flag,
   input wire logic [1:0][15:0] level_mv
);
   // nominal millivolts; low steps truncate, high steps round to nearest
   function automatic logic [15:0] mv(input logic [3:0] c);
      mv = c[3] ? 16'h467a + (c[2:0] * 16'h03e8 + 16'h0001) / 16'h0003
         : 16'h31a5 + c[2:0] * 16'h03e8 / 16'h0003;
   endfunction : mv
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // field capture, selection and decode
   a_timer_on: assert property (overcurrent_timer_active == 2'h3)
      else $error("timer output off");
   a_ch1_volt: assert property (wr_strobe && wr_data[7:6] == 2'h0 |=>
      volt_code[0] == $past(wr_data[3:0]) && supply_enable[0] == $past(wr_data[5]))
      else $error("ch1 voltage write");
   a_tone_src: assert property (wr_strobe && wr_data[7] |=>
      tone_source[$past(wr_data[6])] == $past(wr_data[0])) else $error("tone source");
   a_cable_drive: assert property (wr_strobe && wr_data[7:6] == 2'h2 |=> ##1
      regulator_disable[0] == $past(wr_data[2], 2)) else $error("cable test drive");
   a_level_map: assert property (level_mv[0] == mv($past(volt_code[0])))
      else $error("level decode");
   a_other_hold: assert property (wr_strobe && wr_data[7:6] != 2'h0 |=>
      $stable(volt_code[0]) && $stable(supply_enable[0])) else $error("ch1 disturbed");
   // disconnect flag against test state and comparator
   a_flag_idle: assert property (!regulator_disable[0] |-> !cable_disconnected_flag[0])
      else $error("flag without test");
   a_flag_set: assert property (regulator_disable[0] && $past(cmp_above_21v[0], 3) |->
      cable_disconnected_flag[0]) else $error("flag not set");
   // below 19.95 V with the upper comparator quiet clears the flag
   a_flag_clear: assert property (regulator_disable[0] && $past(cmp_below_19v95[0], 3) &&
      !$past(cmp_above_21v[0], 3) |-> !cable_disconnected_flag[0]) else $error("flag not cleared");
   c_ch2_tone: cover property (wr_strobe && wr_data[7:6] == 2'h3);
   c_flag: cover property (cable_disconnected_flag[0]);
   c_high: cover property (volt_code[0] == 4'hf);
endmodule : lnbc_bank_checker

// >>> testbench/tb.sv
/* tb: self-checking bench of the control bank driven by the host model.
   assumes a 20 MHz clock and the checker bound onto the bank */
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic int_tone_in = 1'b0;
   logic [1:0] ext_tone_in = 2'h0;
   logic [1:0] ext_mod_gating_in = 2'h0;
   logic [1:0] cmp_above_21v = 2'h0;
   logic [1:0] cmp_below_19v95 = 2'h0;
   logic [7:0] wr_data;
   logic wr_strobe;
   logic [1:0][3:0] volt_code;
   logic [1:0][15:0] level_mv;
   logic [1:0] supply_enable, overcurrent_timer_active, tone_source, tone_out;
   logic [1:0] regulator_disable, current_source_enable, boost_raise, cable_disconnected_flag;
   int n_errors = 0;
   int checked = 0;
   // 50 ns period
   always #25 clk = ~clk;
   lnbc_host_model i_host (.clk, .wr_data, .wr_strobe);
   lnbc_bank i_dut (.clk, .arst_n, .wr_data, .wr_strobe, .int_tone_in, .ext_tone_in,
      .ext_mod_gating_in, .cmp_above_21v, .cmp_below_19v95, .volt_code, .supply_enable,
      .overcurrent_timer_active, .tone_source, .tone_out, .regulator_disable,
      .current_source_enable, .boost_raise, .cable_disconnected_flag, .level_mv);
   task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", s, x, g);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask : w
   task automatic give_verdict;
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task automatic t_reset;
      chk("fields", 32'h0, {16'h0, volt_code, supply_enable, tone_source, tone_out,
         cable_disconnected_flag});
      chk("drive", 32'h3, {24'h0, regulator_disable, current_source_enable, boost_raise,
         overcurrent_timer_active});
      chk("level", {2{16'h31a5}}, level_mv);
   endtask : t_reset
   // every code on ch1, complement on ch2, back to back
   task automatic t_volt;
      for (int c = 0; c < 16; c++) begin
         i_host.send({2'h0, c[0], c[1], 4'(c)});
         i_host.send({2'h1, ~c[0], 1'b1, 4'(15 - c)});
         w(2);
         chk("volt_code", {24'h0, 4'(15 - c), 4'(c)}, {24'h0, volt_code});
         chk("supply_enable", {30'h0, ~c[0], c[0]}, {30'h0, supply_enable});
      end
      chk("level_mv", {16'h31a5, 16'h4f97}, level_mv);
   endtask : t_volt
   // source, gate and external gating in all combinations
   task automatic t_tone;
      logic e;
      for (int k = 0; k < 16; k++) begin
         @(posedge clk);
         ext_tone_in <= {1'b0, k[3]};
         int_tone_in <= ~k[3];
         ext_mod_gating_in <= {1'b0, k[2]};
         i_host.send({2'h2, 3'h7, 1'b0, k[1], k[0]});
         w(4);
         e = (k[0] ? ~k[3] : k[3]) & (k[2] ? k[3] : k[1]);
         chk("tone_out", {31'h0, e}, {31'h0, tone_out[0]});
      end
      i_host.send(8'hc1);
      w(4);
      chk("ch2 tone", 32'h2, {30'h0, tone_source[1], tone_out[1]});
      chk("volt kept", 32'h0f, {24'h0, volt_code});
   endtask : t_tone
   task automatic t_cable;
      i_host.send(8'h2f);
      i_host.send(8'h84);
      w(2);
      chk("drive", 32'h7, {29'h0, regulator_disable[0], current_source_enable[0],
         boost_raise[0]});
      cmp_above_21v <= 2'h1;
      w(4);
      chk("flag set", 32'h1, {31'h0, cable_disconnected_flag[0]});
      cmp_above_21v <= 2'h0;
      cmp_below_19v95 <= 2'h1;
      w(4);
      chk("flag clear", 32'h0, {31'h0, cable_disconnected_flag[0]});
   endtask : t_cable
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      w(5000);
      n_errors++;
      give_verdict;
   end
   initial begin
      w(16);
      t_reset;
      arst_n <= 1'b1;
      t_volt;
      t_tone;
      t_cable;
      give_verdict;
   end
endmodule : tb
bind lnbc_bank lnbc_bank_checker i_chk (.clk, .arst_n, .wr_data, .wr_strobe, .cmp_above_21v,
   .cmp_below_19v95,
   .volt_code, .supply_enable, .overcurrent_timer_active, .tone_source, .regulator_disable,
   .cable_disconnected_flag, .level_mv);
